// ### core/qfs_pkg.sv
/*
  Shared constants and types for the queue flag and status output block:
  register map, field positions, reset values, width and mode codes.
  Assumes an APB master with 32-bit data and byte addresses.
*/
`default_nettype none

package qfs_pkg;

  // Queue and expansion sizing
  localparam int QUEUES = 4;
  localparam int QSEL_W = 2;
  localparam int DEV_W = 3;
  localparam int ADDR_W = QSEL_W + DEV_W;
  localparam int APB_AW = 8;

  // Synchronised pin vector positions
  localparam int PIN_MRS = 0;
  localparam int PIN_OUTW = 1;
  localparam int PIN_INW = 2;
  localparam int PIN_MATCH = 3;
  localparam int PIN_FLAGM = 4;
  localparam int PIN_PKT = 5;
  localparam int PIN_PD = 6;
  localparam int SYNC_W = 7;

  // Register offsets
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;

  // Control register fields and reset values
  localparam int CTRL_DEV_LSB = 0;
  localparam int CTRL_IO_LSB = 3;
  localparam logic [DEV_W-1:0] CTRL_DEV_RESET = 3'h0;

  // Status register fields
  localparam int STAT_INW_LSB = 0;
  localparam int STAT_OUTW_LSB = 2;
  localparam int STAT_PKT_BIT = 4;
  localparam int STAT_POLL_BIT = 5;
  localparam int STAT_RUN_BIT = 6;
  localparam int STAT_RDQ_LSB = 8;
  localparam int STAT_RDMINE_BIT = 10;
  localparam int STAT_WRQ_LSB = 12;
  localparam int STAT_WRMINE_BIT = 14;
  localparam int STAT_PDIS_BIT = 15;

  // Port width codes
  typedef enum logic [1:0] {
    QFS_W9 = 2'h0,
    QFS_W18 = 2'h1,
    QFS_W36 = 2'h2
  } qfs_width_type;

  // I/O standard codes
  typedef enum logic [1:0] {
    QFS_IO_LVTTL = 2'h0,
    QFS_IO_HSTL = 2'h1,
    QFS_IO_EHSTL = 2'h2,
    QFS_IO_RSVD = 2'h3
  } qfs_io_type;

  // Master reset state, one-hot
  typedef enum logic [1:0] {
    QFS_ST_MRS = 2'h1,
    QFS_ST_RUN = 2'h2
  } qfs_state_type;

endpackage

`default_nettype wire

// ### core/qfs_sync.sv
/*
  Two flip-flop synchroniser, one stage pair per bit.
  Assumes inputs are quasi-static pins from outside the pclk domain.
*/
`default_nettype none

module qfs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // One independent two-stage chain per bit; first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= d[gi];
          sync_ff <= meta_ff;
        end
      end
      assign q[gi] = sync_ff;
    end
  endgenerate

endmodule

`default_nettype wire

// ### core/qfs_flag_status.sv
/*
  Queue flag and status outputs: discrete almost-empty, packet-ready and
  almost-full flags, the two shared flag buses, reset-time configuration
  and the power-down gate, plus an APB register slave.
  Assumes queue status inputs and host address/strobe inputs are on pclk;
  configuration pins and master reset are asynchronous and synchronised here.
*/
// Our own choices: register access over APB and the placing of the registers.
`default_nettype none

module qfs_flag_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [qfs_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_reset_n,
  input wire logic output_width_pin,
  input wire logic input_width_pin,
  input wire logic bus_match_select,
  input wire logic flag_mode_select,
  input wire logic packet_mode_select,
  input wire logic power_down_input,
  input wire logic [qfs_pkg::QUEUES-1:0] queue_almost_empty,
  input wire logic [qfs_pkg::QUEUES-1:0] queue_almost_full,
  input wire logic [qfs_pkg::QUEUES-1:0] queue_packet_ready,
  input wire logic [qfs_pkg::ADDR_W-1:0] read_queue_address,
  input wire logic read_address_enable,
  input wire logic read_flag_strobe,
  input wire logic [qfs_pkg::ADDR_W-1:0] write_queue_address,
  input wire logic write_address_enable,
  input wire logic write_flag_strobe,
  output logic almost_empty_flag,
  output logic packet_ready_flag,
  output logic almost_full_flag,
  output logic [qfs_pkg::QUEUES-1:0] read_status_bus_o,
  output logic read_status_bus_oe,
  output logic [qfs_pkg::QUEUES-1:0] write_status_bus_o,
  output logic write_status_bus_oe,
  output logic write_data_disable,
  output logic [1:0] input_width_code,
  output logic [1:0] output_width_code
);
  import qfs_pkg::*;

  logic [SYNC_W-1:0] pins_s;
  logic run;
  qfs_state_type state_ff, nxt_state;
  qfs_width_type in_w_ff, nxt_in_w, out_w_ff, nxt_out_w;
  logic pkt_ff, nxt_pkt, polled_ff, nxt_polled;
  logic [DEV_W-1:0] dev_id_ff, nxt_dev_id;
  qfs_io_type io_ff, nxt_io;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [QSEL_W-1:0] rd_q_ff, nxt_rd_q, wr_q_ff, nxt_wr_q;
  logic rd_mine_ff, nxt_rd_mine, wr_mine_ff, nxt_wr_mine;
  logic rd_strb_ff, nxt_rd_strb, wr_strb_ff, nxt_wr_strb;
  logic [DEV_W-1:0] rd_poll_ff, nxt_rd_poll, wr_poll_ff, nxt_wr_poll;
  logic ae_ff, nxt_ae, pkt_rdy_ff, nxt_pkt_rdy, af_ff, nxt_af;
  logic [QUEUES-1:0] rbus_ff, nxt_rbus, wbus_ff, nxt_wbus;
  logic rbus_oe_ff, nxt_rbus_oe, wbus_oe_ff, nxt_wbus_oe, pdis_ff, nxt_pdis;

  // Pins from outside the clock domain, master reset first
  qfs_sync #(.WIDTH(SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({power_down_input, packet_mode_select, flag_mode_select, bus_match_select,
        input_width_pin, output_width_pin, master_reset_n}),
    .q(pins_s)
  );

  assign run = (state_ff == QFS_ST_RUN);

  // Configuration tracks the pins while master reset is low and freezes at release
  always_comb begin
    nxt_state = state_ff;
    nxt_in_w = in_w_ff;
    nxt_out_w = out_w_ff;
    nxt_pkt = pkt_ff;
    nxt_polled = polled_ff;
    case (state_ff)
      QFS_ST_MRS: begin
        if (pins_s[PIN_MRS]) begin
          nxt_state = QFS_ST_RUN;
        end
      end
      QFS_ST_RUN: begin
        if (!pins_s[PIN_MRS]) begin
          nxt_state = QFS_ST_MRS;
        end
      end
      default: nxt_state = QFS_ST_MRS;
    endcase
    if (!pins_s[PIN_MRS]) begin
      // Width pins are only read here, so later toggles are harmless
      nxt_in_w = QFS_W36;
      nxt_out_w = QFS_W36;
      if (pins_s[PIN_MATCH]) begin
        if (pins_s[PIN_INW]) begin
          nxt_in_w = pins_s[PIN_OUTW] ? QFS_W9 : QFS_W18;
        end else begin
          nxt_out_w = pins_s[PIN_OUTW] ? QFS_W9 : QFS_W18;
        end
      end
      // Packet request is dropped unless both ports end up 36 wide
      nxt_pkt = pins_s[PIN_PKT] && nxt_in_w == QFS_W36 && nxt_out_w == QFS_W36;
      nxt_polled = pins_s[PIN_FLAGM];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= QFS_ST_MRS;
      in_w_ff <= QFS_W36;
      out_w_ff <= QFS_W36;
      pkt_ff <= 1'b0;
      polled_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      in_w_ff <= nxt_in_w;
      out_w_ff <= nxt_out_w;
      pkt_ff <= nxt_pkt;
      polled_ff <= nxt_polled;
    end
  end

  // APB slave: one wait state so that read data and error come from flops
  always_comb begin
    nxt_dev_id = dev_id_ff;
    nxt_io = io_ff;
    nxt_pready = psel && penable && !pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0;
    if (psel && penable && !pready_ff) begin
      if (paddr == ADDR_CTRL) begin
        nxt_prdata[CTRL_DEV_LSB +: DEV_W] = dev_id_ff;
        nxt_prdata[CTRL_IO_LSB +: 2] = io_ff;
      end else if (paddr == ADDR_STATUS) begin
        nxt_prdata[STAT_INW_LSB +: 2] = in_w_ff;
        nxt_prdata[STAT_OUTW_LSB +: 2] = out_w_ff;
        nxt_prdata[STAT_PKT_BIT] = pkt_ff;
        nxt_prdata[STAT_POLL_BIT] = polled_ff;
        nxt_prdata[STAT_RUN_BIT] = run;
        nxt_prdata[STAT_RDQ_LSB +: QSEL_W] = rd_q_ff;
        nxt_prdata[STAT_RDMINE_BIT] = rd_mine_ff;
        nxt_prdata[STAT_WRQ_LSB +: QSEL_W] = wr_q_ff;
        nxt_prdata[STAT_WRMINE_BIT] = wr_mine_ff;
        nxt_prdata[STAT_PDIS_BIT] = pdis_ff;
      end else begin
        nxt_pslverr = 1'b1;
      end
    end
    // Write lands on the completing edge; status writes are ignored
    if (psel && penable && pready_ff && pwrite && paddr == ADDR_CTRL && pstrb[0]) begin
      nxt_dev_id = pwdata[CTRL_DEV_LSB +: DEV_W];
      nxt_io = qfs_io_type'(pwdata[CTRL_IO_LSB +: 2]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_id_ff <= CTRL_DEV_RESET;
      io_ff <= QFS_IO_LVTTL;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      dev_id_ff <= nxt_dev_id;
      io_ff <= nxt_io;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // Read side: queue select, strobe capture, poll slot, flags and bus
  always_comb begin
    nxt_rd_q = rd_q_ff;
    nxt_rd_mine = rd_mine_ff;
    nxt_rd_strb = rd_strb_ff;
    nxt_rd_poll = 3'(rd_poll_ff + 3'h1);
    if (read_address_enable) begin
      nxt_rd_q = read_queue_address[QSEL_W-1:0];
      nxt_rd_mine = (read_queue_address[ADDR_W-1:QSEL_W] == dev_id_ff);
    end
    if (read_flag_strobe) begin
      nxt_rd_strb = (read_queue_address[ADDR_W-1:QSEL_W] == dev_id_ff);
    end
    // Flags are active low and idle high when another device is selected
    nxt_ae = !(rd_mine_ff && queue_almost_empty[rd_q_ff]);
    nxt_pkt_rdy = !(pkt_ff && rd_mine_ff && queue_packet_ready[rd_q_ff]);
    nxt_rbus = pkt_ff ? ~queue_packet_ready : ~queue_almost_empty;
    nxt_rbus_oe = polled_ff ? (rd_poll_ff == dev_id_ff) : rd_strb_ff;
    if (!run) begin
      nxt_rd_q = '0;
      nxt_rd_mine = 1'b0;
      nxt_rd_strb = 1'b0;
      nxt_rd_poll = '0;
      nxt_ae = 1'b1;
      nxt_pkt_rdy = 1'b1;
      nxt_rbus = '1;
      nxt_rbus_oe = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q_ff <= '0;
      rd_mine_ff <= 1'b0;
      rd_strb_ff <= 1'b0;
      rd_poll_ff <= '0;
      ae_ff <= 1'b1;
      pkt_rdy_ff <= 1'b1;
      rbus_ff <= '1;
      rbus_oe_ff <= 1'b0;
    end else begin
      rd_q_ff <= nxt_rd_q;
      rd_mine_ff <= nxt_rd_mine;
      rd_strb_ff <= nxt_rd_strb;
      rd_poll_ff <= nxt_rd_poll;
      ae_ff <= nxt_ae;
      pkt_rdy_ff <= nxt_pkt_rdy;
      rbus_ff <= nxt_rbus;
      rbus_oe_ff <= nxt_rbus_oe;
    end
  end

  // Write side mirrors the read side; power-down gate lives here too
  always_comb begin
    nxt_wr_q = wr_q_ff;
    nxt_wr_mine = wr_mine_ff;
    nxt_wr_strb = wr_strb_ff;
    nxt_wr_poll = 3'(wr_poll_ff + 3'h1);
    if (write_address_enable) begin
      nxt_wr_q = write_queue_address[QSEL_W-1:0];
      nxt_wr_mine = (write_queue_address[ADDR_W-1:QSEL_W] == dev_id_ff);
    end
    if (write_flag_strobe) begin
      nxt_wr_strb = (write_queue_address[ADDR_W-1:QSEL_W] == dev_id_ff);
    end
    nxt_af = !(wr_mine_ff && queue_almost_full[wr_q_ff]);
    nxt_wbus = ~queue_almost_full;
    nxt_wbus_oe = polled_ff ? (wr_poll_ff == dev_id_ff) : wr_strb_ff;
    // LVTTL ignores the pin, so reserved codes count as high-speed
    nxt_pdis = pins_s[PIN_PD] && io_ff != QFS_IO_LVTTL;
    if (!run) begin
      nxt_wr_q = '0;
      nxt_wr_mine = 1'b0;
      nxt_wr_strb = 1'b0;
      nxt_wr_poll = '0;
      nxt_af = 1'b1;
      nxt_wbus = '1;
      nxt_wbus_oe = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q_ff <= '0;
      wr_mine_ff <= 1'b0;
      wr_strb_ff <= 1'b0;
      wr_poll_ff <= '0;
      af_ff <= 1'b1;
      wbus_ff <= '1;
      wbus_oe_ff <= 1'b0;
      pdis_ff <= 1'b0;
    end else begin
      wr_q_ff <= nxt_wr_q;
      wr_mine_ff <= nxt_wr_mine;
      wr_strb_ff <= nxt_wr_strb;
      wr_poll_ff <= nxt_wr_poll;
      af_ff <= nxt_af;
      wbus_ff <= nxt_wbus;
      wbus_oe_ff <= nxt_wbus_oe;
      pdis_ff <= nxt_pdis;
    end
  end

  // Every output straight from a flop
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign almost_empty_flag = ae_ff;
  assign packet_ready_flag = pkt_rdy_ff;
  assign almost_full_flag = af_ff;
  assign read_status_bus_o = rbus_ff;
  assign read_status_bus_oe = rbus_oe_ff;
  assign write_status_bus_o = wbus_ff;
  assign write_status_bus_oe = wbus_oe_ff;
  assign write_data_disable = pdis_ff;
  assign input_width_code = in_w_ff;
  assign output_width_code = out_w_ff;

  // Checks on the flag and configuration behaviour
  AST_ONE_PORT_36: assert property (@(posedge pclk) disable iff (!presetn)
    in_w_ff == QFS_W36 || out_w_ff == QFS_W36) else $error("neither port is 36 wide");

  AST_AE_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    run && pins_s[PIN_MRS] && rd_mine_ff && queue_almost_empty[rd_q_ff] |=> !almost_empty_flag)
    else $error("almost-empty flag not low for selected queue");

  AST_RD_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
    run && read_address_enable && read_queue_address[ADDR_W-1:QSEL_W] == dev_id_ff
    |=> rd_mine_ff && rd_q_ff == $past(read_queue_address[QSEL_W-1:0])) else $error("read queue not selected");

  AST_AF_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    run && pins_s[PIN_MRS] && wr_mine_ff && queue_almost_full[wr_q_ff] |=> !almost_full_flag)
    else $error("almost-full flag not low for selected queue");

  AST_WR_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
    run && write_address_enable && write_queue_address[ADDR_W-1:QSEL_W] == dev_id_ff
    |=> wr_mine_ff && wr_q_ff == $past(write_queue_address[QSEL_W-1:0])) else $error("write queue not selected");

  AST_CFG_FROZEN: assert property (@(posedge pclk) disable iff (!presetn)
    run && pins_s[PIN_MRS] |=> $stable(pkt_ff) && $stable(polled_ff) && $stable(in_w_ff))
    else $error("configuration changed outside master reset");

  AST_BUS_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> !read_status_bus_oe && !write_status_bus_oe) else $error("flag bus driven during master reset");

  AST_RD_DIRECT: assert property (@(posedge pclk) disable iff (!presetn)
    run && pins_s[PIN_MRS] && !polled_ff && read_flag_strobe
    && read_queue_address[ADDR_W-1:QSEL_W] == dev_id_ff |=> ##1 read_status_bus_oe)
    else $error("read bus not driven after matching strobe");

  AST_WR_DIRECT: assert property (@(posedge pclk) disable iff (!presetn)
    run && pins_s[PIN_MRS] && !polled_ff && write_flag_strobe
    && write_queue_address[ADDR_W-1:QSEL_W] == dev_id_ff |=> ##1 write_status_bus_oe)
    else $error("write bus not driven after matching strobe");

  AST_POLL_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    run && pins_s[PIN_MRS] |=> rd_poll_ff == 3'($past(rd_poll_ff) + 3'h1) && wr_poll_ff == rd_poll_ff)
    else $error("poll slot did not advance");

  AST_PD_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    pins_s[PIN_PD] && io_ff != QFS_IO_LVTTL |=> write_data_disable) else $error("power-down not applied");

  AST_PD_LVTTL: assert property (@(posedge pclk) disable iff (!presetn)
    io_ff == QFS_IO_LVTTL && $past(io_ff) == QFS_IO_LVTTL |-> !write_data_disable)
    else $error("power-down acted in LVTTL mode");

  AST_PKTRDY_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !pkt_ff [*2] |-> packet_ready_flag) else $error("packet-ready flag active in almost-empty mode");

  AST_PKT_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_ff |-> in_w_ff == QFS_W36 && out_w_ff == QFS_W36) else $error("packet mode without 36-bit ports");

endmodule

`default_nettype wire

// ### sim/qfs_peer_model.sv
/*
  Expanded peer device on the two shared flag buses, direct mode only.
  Assumes the buses carry pull-ups, so a released bus reads all ones.
*/
`default_nettype none

module qfs_peer_model #(
  parameter logic [2:0] PEER_ID = 3'h2,
  parameter logic [3:0] PEER_STATUS = 4'hA
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [qfs_pkg::ADDR_W-1:0] read_queue_address,
  input wire logic read_flag_strobe,
  input wire logic [qfs_pkg::ADDR_W-1:0] write_queue_address,
  input wire logic write_flag_strobe,
  input wire logic [3:0] dut_rd_o,
  input wire logic dut_rd_oe,
  input wire logic [3:0] dut_wr_o,
  input wire logic dut_wr_oe,
  output logic [3:0] rd_wire,
  output logic [3:0] wr_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  import qfs_pkg::*;
  logic [1:0] rd_sel_ff, wr_sel_ff, nxt_rd_sel, nxt_wr_sel;

  // Selection kept until a strobe names another device; two stages match the block's own lag
  always_comb begin
    nxt_rd_sel = {rd_sel_ff[0], rd_sel_ff[0]};
    nxt_wr_sel = {wr_sel_ff[0], wr_sel_ff[0]};
    if (read_flag_strobe) nxt_rd_sel[0] = (read_queue_address[ADDR_W-1:QSEL_W] == PEER_ID);
    if (write_flag_strobe) nxt_wr_sel[0] = (write_queue_address[ADDR_W-1:QSEL_W] == PEER_ID);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_sel_ff <= 2'h0;
      wr_sel_ff <= 2'h0;
    end else begin
      rd_sel_ff <= nxt_rd_sel;
      wr_sel_ff <= nxt_wr_sel;
    end
  end

  // Wire level from every party's enable; nobody driving means pull-up
  assign rd_wire = dut_rd_oe ? dut_rd_o : (rd_sel_ff[1] ? PEER_STATUS : 4'hF);
  assign wr_wire = dut_wr_oe ? dut_wr_o : (wr_sel_ff[1] ? PEER_STATUS : 4'hF);
endmodule

`default_nettype wire

// ### sim/tb_queue_flag_status_outputs.sv
/*
  Self-checking bench for the queue flag and status block.
  Assumes one clock pclk; APB answers are noted in a queue and checked at pready.
*/
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module tb_queue_flag_status_outputs;
  timeunit 1ns;
  timeprecision 1ps;
  import qfs_pkg::*;
  typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} qfs_note_type;
  localparam logic [2:0] DEV = 3'h5;
  localparam logic [2:0] PEER = 3'h2;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rng = 32'h5;
  logic mrs_n = 1'b0, owid = 1'b0, iwid = 1'b0, bmatch = 1'b0, fmode = 1'b0, pkt = 1'b0, pd = 1'b0;
  logic ren = 1'b0, rstb = 1'b0, wen = 1'b0, wstb = 1'b0;
  logic [3:0] ae = 4'h0, af = 4'h0, prdy = 4'h0, rd_o, wr_o, rd_wire, wr_wire;
  logic [4:0] raddr = 5'h00, waddr = 5'h00;
  logic aef, prf, aff, rd_oe, wr_oe, wdd;
  logic [1:0] inw, outw;
  int n_mismatch = 0, n_checks = 0;
  qfs_note_type notes[$];

  always #5 pclk = ~pclk;

  qfs_flag_status dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_reset_n(mrs_n), .output_width_pin(owid), .input_width_pin(iwid), .bus_match_select(bmatch),
    .flag_mode_select(fmode), .packet_mode_select(pkt), .power_down_input(pd), .queue_almost_empty(ae),
    .queue_almost_full(af), .queue_packet_ready(prdy), .read_queue_address(raddr), .read_address_enable(ren),
    .read_flag_strobe(rstb), .write_queue_address(waddr), .write_address_enable(wen),
    .write_flag_strobe(wstb), .almost_empty_flag(aef), .packet_ready_flag(prf), .almost_full_flag(aff),
    .read_status_bus_o(rd_o), .read_status_bus_oe(rd_oe), .write_status_bus_o(wr_o),
    .write_status_bus_oe(wr_oe), .write_data_disable(wdd), .input_width_code(inw), .output_width_code(outw));

  qfs_peer_model #(.PEER_ID(PEER), .PEER_STATUS(4'hA)) peer_u (.pclk(pclk), .presetn(presetn),
    .read_queue_address(raddr), .read_flag_strobe(rstb), .write_queue_address(waddr),
    .write_flag_strobe(wstb), .dut_rd_o(rd_o), .dut_rd_oe(rd_oe), .dut_wr_o(wr_o), .dut_wr_oe(wr_oe),
    .rd_wire(rd_wire), .wr_wire(wr_wire));

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; the answer is checked by the monitor from the note
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp_d,
                     input logic [31:0] mask, input logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    notes.push_back('{exp_d, mask, err});
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin n_mismatch++; give_verdict(); end
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Oldest note against each answer as it appears
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin n_mismatch++; $display("MISMATCH apb_note expected 1 seen 0"); end
      else begin
        `CHK("pslverr", notes[0].err, pslverr)
        `CHK("prdata", notes[0].data & notes[0].mask, prdata & notes[0].mask)
        void'(notes.pop_front());
      end
    end
  end

  // Reset pulse with config pins, then master reset release
  task automatic configure(input logic [4:0] cfg);
    @(posedge pclk);
    presetn <= 1'b0; mrs_n <= 1'b0;
    {bmatch, iwid, owid, fmode, pkt} <= cfg;
    cyc(3);
    presetn <= 1'b1;
    cyc(5);
    mrs_n <= 1'b1; // pins stay put from here on
    cyc(6);
  endtask

  // Select a queue on both sides and check discrete flags
  task automatic sel_check(input logic [2:0] dev, input logic [1:0] q, input logic epkt);
    @(posedge pclk);
    raddr <= {dev, q}; waddr <= {dev, q}; ren <= 1'b1; wen <= 1'b1;
    @(posedge pclk);
    ren <= 1'b0; wen <= 1'b0;
    cyc(3);
    #1;
    `CHK("ae_flag", (dev == DEV) ? ~ae[q] : 1'b1, aef)
    `CHK("af_flag", (dev == DEV) ? ~af[q] : 1'b1, aff)
    `CHK("pr_flag", (dev == DEV && epkt) ? ~prdy[q] : 1'b1, prf)
  endtask

  task automatic strobe(input logic [2:0] dev);
    @(posedge pclk);
    raddr <= {dev, 2'h0}; waddr <= {dev, 2'h0}; rstb <= 1'b1; wstb <= 1'b1;
    @(posedge pclk);
    rstb <= 1'b0; wstb <= 1'b0;
    cyc(4);
    #1;
  endtask

  // Match, in pin, out pin, flag mode, packet; then expected in, out, packet
  logic [4:0] cfgs[5] = '{5'b00001, 5'b10111, 5'b11000, 5'b10011, 5'b11100};
  logic [1:0] ein[5] = '{2'h2, 2'h2, 2'h1, 2'h2, 2'h0};
  logic [1:0] eout[5] = '{2'h2, 2'h0, 2'h2, 2'h1, 2'h2};
  logic epk[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  initial begin
    int k, q, nr, nw;
    cyc(3);
    #1;
    `CHK("rst_flags", 3'h7, {aef, prf, aff})
    `CHK("rst_oe", 2'h0, {rd_oe, wr_oe})
    for (k = 0; k < 5; k++) begin
      configure(cfgs[k]);
      #1;
      `CHK("in_width", ein[k], inw)
      `CHK("out_width", eout[k], outw)
      apb(1'b0, ADDR_CTRL, 32'h0, 32'h0, 32'h1F, 1'b0);
      apb(1'b1, ADDR_CTRL, {29'h0, DEV}, 32'h0, 32'h0, 1'b0);
      apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0, {26'h1, cfgs[k][1], epk[k], eout[k], ein[k]}, 32'h7F, 1'b0);
      apb(1'b0, 8'h08, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
      {ae, af, prdy} <= 12'(xs());
      for (q = 0; q < 4; q++) sel_check(DEV, q[1:0], epk[k]);
      sel_check(PEER, 2'h1, epk[k]);
      if (cfgs[k][1] == 1'b0) begin
        strobe(DEV);
        `CHK("rd_bus", epk[k] ? ~prdy : ~ae, rd_wire)
        `CHK("wr_bus", ~af, wr_wire)
        `CHK("oe_mine", 2'h3, {rd_oe, wr_oe})
        strobe(PEER);
        `CHK("oe_peer", 2'h0, {rd_oe, wr_oe})
        `CHK("rd_peer", 4'hA, rd_wire)
      end else begin
        nr = 0;
        nw = 0;
        for (q = 0; q < 32; q++) begin
          @(posedge pclk);
          #1;
          if (rd_oe === 1'b1) begin nr++; `CHK("poll_rd", ~ae, rd_o) end
          if (wr_oe === 1'b1) begin nw++; `CHK("poll_wr", ~af, wr_o) end
        end
        `CHK("poll_rd_n", 4, nr)
        `CHK("poll_wr_n", 4, nw)
      end
      $display("test config %0d done", k);
    end
    @(posedge pclk);
    pd <= 1'b1;
    cyc(5);
    #1;
    `CHK("pd_lvttl", 1'b0, wdd)
    for (k = 1; k < 4; k++) begin
      apb(1'b1, ADDR_CTRL, {27'h0, k[1:0], DEV}, 32'h0, 32'h0, 1'b0);
      cyc(5);
      #1;
      `CHK("pd_hs", 1'b1, wdd)
    end
    @(posedge pclk);
    pd <= 1'b0;
    cyc(5);
    #1;
    `CHK("pd_off", 1'b0, wdd)
    $display("test power_down done");
    give_verdict();
  end

  // Hang guard
  initial begin
    #500000;
    n_mismatch++;
    give_verdict();
  end
endmodule

`default_nettype wire
